// ==== bus_if_params.svh ====
// Constants for the transfer controller bus interface
`ifndef BUS_IF_PARAMS_SVH
`define BUS_IF_PARAMS_SVH
`define CHANNELS 4
`define MODE_BURST 2'b00
`define MODE_RSVD 2'b01
`define MODE_STEAL 2'b10
`define MODE_STEAL_HOLD 2'b11
`define EXC_NONE 3'h0
`define EXC_HALT 3'h2
`define FC_RESET 3'h0
`define VEC_RESET 8'h0f
`endif

// ==== bus_if_pkg.sv ====
// Types shared by the transfer controller bus interface
`default_nettype none
package bus_if_pkg;
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_HOST = 2'b01,
    MODE_DMA = 2'b10
  } bus_mode_e;
  typedef enum logic [2:0] {
    ARB_IDLE = 3'b000,
    ARB_REQ = 3'b001,
    ARB_WAIT = 3'b010,
    ARB_OWN = 3'b011,
    ARB_CYCLE = 3'b100
  } arb_state_e;
endpackage : bus_if_pkg
`default_nettype wire

// ==== bus_partner_model.sv ====
// Arbiter and memory model on the far side of the system bus
`default_nettype none
module bus_partner_model
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bus_request_out_n,
  input wire logic strobe_n,
  input wire logic strobe_oe,
  input wire logic hang,
  input wire logic [2:0] exc,
  output logic bus_grant_in_n,
  output logic ack_n,
  output logic [2:0] exception_code_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] cnt;
  // Grant follows request one cycle late; acknowledge three cycles into a strobe
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      bus_grant_in_n <= 1'b1;
      ack_n <= 1'b1;
      exception_code_n <= 3'h7;
      cnt <= 2'h0;
    end
    else
    begin
      bus_grant_in_n <= bus_request_out_n;
      cnt <= (strobe_oe && !strobe_n && cnt != 2'h3) ? cnt + 2'h1 : (strobe_n ? 2'h0 : cnt);
      // Exception rides with the acknowledge so it must win over it
      if (strobe_oe && !strobe_n && cnt == 2'h2 && !hang)
      begin
        ack_n <= 1'b0;
        exception_code_n <= ~exc;
      end
      else if (strobe_n || !strobe_oe)
      begin
        ack_n <= 1'b1; // Pulled up once released
        exception_code_n <= 3'h7;
      end
    end
  end
endmodule : bus_partner_model
`default_nettype wire

// ==== demand_detect.sv ====
// Per-channel demand detector: falling edge or low level by request mode
`default_nettype none
`include "bus_if_params.svh"
module demand_detect
  import bus_if_pkg::*;
#(
  parameter int CH = 4
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [CH-1:0] demand_n,
  input wire logic [2*CH-1:0] request_mode,
  input wire logic [CH-1:0] served,
  output logic [CH-1:0] pending
);
  logic [CH-1:0] prev_n;

  // Previous sampled level for edge detection
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      prev_n <= {CH{1'b1}};
    else
      prev_n <= demand_n;
  end

  genvar i;
  generate
    for (i = 0; i < CH; i++)
    begin : g_ch
      logic steal;
      assign steal = request_mode[2*i+1];
      // Cycle steal latches the edge; burst follows the level
      always_ff @(posedge clk)
      begin
        if (!reset_n)
          pending[i] <= 1'b0;
        else if (request_mode[2*i +: 2] == `MODE_RSVD)
          pending[i] <= 1'b0;
        else if (steal)
        begin
          if (prev_n[i] && !demand_n[i])
            pending[i] <= 1'b1; // Set wins over serve, see RULE22
          else if (served[i])
            pending[i] <= 1'b0;
        end
        else
          pending[i] <= !demand_n[i]; // see RULE22
      end
    end
  endgenerate
endmodule : demand_detect
`default_nettype wire

// ==== tb_top.sv ====
// Directed testbench for the transfer controller bus interface
`default_nettype none
module tb_top
  import bus_if_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset_n, chip_select_n, vector_fetch_strobe_n, bus_grant_in_n, grant_acknowledge_in_n;
  logic grant_acknowledge_out_n, grant_acknowledge_oe, bus_request_out_n, address_strobe_in_n;
  logic address_strobe_out_n, address_strobe_oe, upper_strobe_in_n, lower_strobe_in_n, strobe_oe;
  logic upper_strobe_out_n, lower_strobe_out_n, read_write_in, read_write_out, read_write_oe;
  logic transfer_acknowledge_in_n, transfer_acknowledge_out_n, transfer_acknowledge_oe, lanes_oe;
  logic low_address_oe, access_space_oe, upper_address_latch_n, upper_address_latch_oe, master_n;
  logic master_oe, buffer_direction, buffer_direction_oe, buffer_enable_n, buffer_enable_oe;
  logic upper_lane_flag_n, upper_lane_flag_oe, interrupt_oe, byte_operand, limited_rate, hang;
  logic cycle_start, cycle_read, release_bus, reg_write, cycle_done, address_error, other_dma_master;
  logic h_as_n, h_us_n, h_ls_n, h_rw, p_ack_n, h_gack_n;
  logic [2:0] exception_code_n, access_space_code, cycle_space, cycle_exception, exc_cmd;
  logic [3:0] demand_n, peripheral_line_n, single_address, served, irq_normal, irq_error, pending;
  logic [7:1] low_address_in, low_address_out, h_addr;
  logic [15:0] lanes_in, lanes_out, cycle_write_data, reg_read_data, reg_write_data, h_lanes;
  logic [15:0] cycle_read_data;
  logic [7:0] external_demand_style, reg_index;
  logic [1:0] bus_mode;
  logic [23:1] cycle_address;
  logic [31:0] normal_vector, error_vector;
  int fails = 0;
  int n_tests = 0;
  // Wire levels from every party's enable
  assign address_strobe_in_n = address_strobe_oe ? address_strobe_out_n : h_as_n;
  assign upper_strobe_in_n = strobe_oe ? upper_strobe_out_n : h_us_n;
  assign lower_strobe_in_n = strobe_oe ? lower_strobe_out_n : h_ls_n;
  assign read_write_in = read_write_oe ? read_write_out : h_rw;
  assign transfer_acknowledge_in_n = transfer_acknowledge_oe ? transfer_acknowledge_out_n : p_ack_n;
  assign grant_acknowledge_in_n = grant_acknowledge_oe ? grant_acknowledge_out_n : h_gack_n;
  assign lanes_in = lanes_oe ? lanes_out : h_lanes;
  assign low_address_in = low_address_oe ? low_address_out : h_addr;
  transfer_controller_bus dut (.*);
  bus_partner_model far (.clk(clk), .reset_n(reset_n), .bus_request_out_n(bus_request_out_n),
    .strobe_n(address_strobe_out_n), .strobe_oe(address_strobe_oe), .hang(hang), .exc(exc_cmd),
    .bus_grant_in_n(bus_grant_in_n), .ack_n(p_ack_n), .exception_code_n(exception_code_n));
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // One owned bus cycle; ab asserts chip select (drives chip_select_n low) mid-cycle to force an abort
  task dma(input logic rd, input logic [2:0] exc, input logic ab);
    int i;
    logic [6:0] ra;
    logic rw, ae;
    logic [2:0] sp;
    logic [15:0] ua, wd;
    logic ul;
    ae = 0;
    @(posedge clk);
    {exc_cmd, hang, cycle_read, cycle_address, cycle_space} <= {exc, ab, rd, 23'h123456, 3'h5};
    if (bus_mode !== MODE_DMA)
    begin
      cycle_start <= 1;
      @(posedge clk);
      cycle_start <= 0;
      for (i = 0; i < 40 && bus_mode !== MODE_DMA; i++) tick(1);
    end
    check(bus_mode, MODE_DMA);
    @(posedge clk);
    cycle_start <= 1;
    @(posedge clk);
    cycle_start <= 0;
    #1;
    {ul, ua} = {upper_address_latch_n, lanes_out};
    for (i = 0; i < 40 && cycle_done !== 1'b1; i++)
    begin
      @(posedge clk);
      chip_select_n <= !(ab && address_strobe_oe === 1'b1);
      #1;
      if (address_strobe_oe === 1'b1 && address_strobe_out_n === 1'b0)
        {ra, rw, sp} = {low_address_out, read_write_out, access_space_code};
      if (strobe_oe === 1'b1 && upper_strobe_out_n === 1'b0) wd = lanes_out;
      ae |= address_error === 1'b1;
    end
    @(posedge clk);
    {chip_select_n, hang} <= 2'b10;
    check(i < 40, 1);
    check({ul, ua}, {1'b0, cycle_address[23:8]});
    if (ab) check(ae, 1);
    else
    begin
      check(ra, cycle_address[7:1]);
      check(rw, rd);
      check(sp, 3'h5);
      check(cycle_exception, exc);
      if (rd) check(cycle_read_data, h_lanes);
      else check(wd, cycle_write_data);
    end
  endtask : dma
  // Host register access with both strobes, write or read
  task host(input logic rw);
    int i;
    logic w;
    w = 0;
    @(posedge clk);
    {chip_select_n, h_as_n, h_us_n, h_ls_n, h_rw, h_addr} <= {4'b0000, rw, 7'h15};
    for (i = 0; i < 30 && !(transfer_acknowledge_oe === 1'b1 && !transfer_acknowledge_out_n); i++)
    begin
      tick(1);
      w |= reg_write === 1'b1;
    end
    check(bus_mode, MODE_HOST);
    check(transfer_acknowledge_oe, 1);
    check(reg_index, {7'h15, 1'b0});
    check(w, !rw);
    if (!rw) check(reg_write_data, h_lanes);
    else check(lanes_in, reg_read_data);
    @(posedge clk);
    {chip_select_n, h_as_n, h_us_n, h_ls_n} <= 4'hf;
    tick(6);
  endtask : host
  // Demand in each request style: burst level, steal edge, reserved
  task demand(input logic [1:0] m);
    @(posedge clk);
    {external_demand_style, demand_n} <= {{4{m}}, 4'h0};
    if (m[1])
    begin
      tick(3);
      demand_n <= 4'hf;
    end
    tick(6);
    check(pending, m == 2'b01 ? 4'h0 : 4'hf);
    {demand_n, served} <= {4'hf, {4{m[1]}}};
    tick(1);
    served <= 0;
    tick(5);
    check(pending, 0);
  endtask : demand
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #50000;
    fails++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    {reset_n, cycle_start, cycle_read, release_bus, byte_operand, limited_rate, hang} = 0;
    {chip_select_n, vector_fetch_strobe_n, h_as_n, h_us_n, h_ls_n, h_rw, h_gack_n} = 7'h7f;
    {demand_n, peripheral_line_n, single_address, served, irq_normal, irq_error} = 24'hff0000;
    {external_demand_style, cycle_space, cycle_address, exc_cmd, h_addr} = 0;
    {cycle_write_data, reg_read_data, h_lanes} = {16'hc33c, 16'h0ff0, 16'h5aa5};
    {normal_vector, error_vector} = {32'h40414243, 32'h50515253};
    repeat (5) @(posedge clk);
    reset_n <= 1;
    tick(4);
    check(bus_mode, MODE_IDLE);
    check({bus_request_out_n, master_oe, lanes_oe, access_space_oe}, 4'h8);
    $display("test reset done");
    dma(1, 3'h0, 0);
    dma(0, 3'h5, 0);
    dma(1, 3'h0, 1);
    @(posedge clk);
    release_bus <= 1;
    @(posedge clk);
    release_bus <= 0;
    tick(4);
    check({bus_mode, master_oe}, {MODE_IDLE, 1'b0});
    $display("test dma done");
    host(0);
    host(1);
    $display("test host done");
    irq_error <= 4'b0100;
    tick(3);
    check(interrupt_oe, 1);
    irq_error <= 0;
    tick(3);
    check(interrupt_oe, 0);
    {vector_fetch_strobe_n, h_as_n} <= 2'b00;
    tick(10);
    check(transfer_acknowledge_oe, 0);
    {irq_normal, irq_error} <= {4'b0100, 4'b1010};
    tick(8);
    check({transfer_acknowledge_out_n, bus_mode}, {1'b0, MODE_HOST});
    check(lanes_in[7:0], error_vector[15:8]);
    {vector_fetch_strobe_n, h_as_n, irq_normal, irq_error} <= 10'h300;
    {limited_rate, h_gack_n} <= 2'b10;
    tick(4);
    check(other_dma_master, 1);
    {limited_rate, h_gack_n} <= 2'b01;
    tick(4);
    check(other_dma_master, 0);
    $display("test vector done");
    for (int k = 0; k < 4; k++) demand(k[1:0]);
    $display("test demand done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire

// ==== transfer_controller_bus.sv ====
// Transfer controller system bus interface: modes, strobes, arbitration, vectors
// Operation
// RULE1 - Sample arbitration and host strobes on falling edge
// RULE2 - Sample exceptions, demands, lines, acknowledge on rising
// RULE3 - Modes: host access, DMA, idle
// RULE4 - Multiplex upper address and data, steer demux
// RULE5 - Low address selects registers or drives address
// RULE6 - Access space code driven only in DMA cycles
// RULE7 - Chip select in own cycle: abort, address error
// RULE8 - Address strobe input, output, watched in arbitration
// RULE9 - Pulse upper address latch, float outside DMA
// RULE10 - Master indicator asserted throughout DMA mode
// RULE11 - Buffer direction and enable, float when idle
// RULE12 - Upper lane flag for single-address byte operands
// RULE13 - Read/write input host, output DMA, float idle
// RULE14 - Data strobes select bytes, act as A0
// RULE15 - Acknowledge driven host, monitored DMA, float idle
// RULE16 - Non-halt exception overrides simultaneous acknowledge
// RULE17 - Outside logic encodes exceptions on code inputs
// RULE18 - Own bus after grant, strobe, acknowledge negate
// RULE19 - Drive grant acknowledge as master; sample in limited-rate
// RULE20 - Return highest-priority channel normal or error vector
// RULE21 - Ignore vector fetch unless interrupt asserted
// RULE22 - Demand: falling edge steal, low level burst
// RULE23 - Two-bit mode: 00 burst, 10/11 steal, 01 reserved
`default_nettype none
`include "bus_if_params.svh"
module transfer_controller_bus
  import bus_if_pkg::*;
#(
  parameter int CH = `CHANNELS
)
(
  input wire logic clk,
  input wire logic reset_n,
  // Host side pins, active low except read/write and the output enables, asynchronous
  input wire logic chip_select_n,
  input wire logic vector_fetch_strobe_n,
  input wire logic bus_grant_in_n,
  input wire logic grant_acknowledge_in_n,
  output logic grant_acknowledge_out_n,
  output logic grant_acknowledge_oe,
  output logic bus_request_out_n,
  input wire logic address_strobe_in_n,
  output logic address_strobe_out_n,
  output logic address_strobe_oe,
  input wire logic upper_strobe_in_n,
  input wire logic lower_strobe_in_n,
  output logic upper_strobe_out_n,
  output logic lower_strobe_out_n,
  output logic strobe_oe,
  input wire logic read_write_in,
  output logic read_write_out,
  output logic read_write_oe,
  input wire logic transfer_acknowledge_in_n,
  output logic transfer_acknowledge_out_n,
  output logic transfer_acknowledge_oe,
  input wire logic [2:0] exception_code_n,
  input wire logic [CH-1:0] demand_n,
  input wire logic [CH-1:0] peripheral_line_n,
  // Address and multiplexed lanes
  input wire logic [7:1] low_address_in,
  output logic [7:1] low_address_out,
  output logic low_address_oe,
  input wire logic [15:0] lanes_in,
  output logic [15:0] lanes_out,
  output logic lanes_oe,
  output logic [2:0] access_space_code,
  output logic access_space_oe,
  output logic upper_address_latch_n,
  output logic upper_address_latch_oe,
  output logic master_n,
  output logic master_oe,
  output logic buffer_direction,
  output logic buffer_direction_oe,
  output logic buffer_enable_n,
  output logic buffer_enable_oe,
  output logic upper_lane_flag_n,
  output logic upper_lane_flag_oe,
  output logic interrupt_oe,
  // Core side
  input wire logic [2*CH-1:0] external_demand_style,
  input wire logic [CH-1:0] single_address,
  input wire logic byte_operand,
  input wire logic limited_rate,
  input wire logic [CH-1:0] served,
  input wire logic cycle_start,
  input wire logic cycle_read,
  input wire logic [23:1] cycle_address,
  input wire logic [15:0] cycle_write_data,
  input wire logic [2:0] cycle_space,
  input wire logic release_bus,
  input wire logic [CH-1:0] irq_normal,
  input wire logic [CH-1:0] irq_error,
  input wire logic [8*CH-1:0] normal_vector,
  input wire logic [8*CH-1:0] error_vector,
  input wire logic [15:0] reg_read_data,
  output logic [CH-1:0] pending,
  output logic [7:0] reg_index,
  output logic reg_write,
  output logic [15:0] reg_write_data,
  output logic [1:0] bus_mode,
  output logic cycle_done,
  output logic [15:0] cycle_read_data,
  output logic [2:0] cycle_exception,
  output logic address_error,
  output logic other_dma_master
);
  // Falling-edge synchronisers (two stages) for host and arbitration pins
  logic [7:0] fs1;
  logic [7:0] fs2;
  always_ff @(negedge clk)
  begin
    if (!reset_n)
    begin
      fs1 <= 8'hff;
      fs2 <= 8'hff;
    end
    else
    begin
      fs1 <= {chip_select_n, vector_fetch_strobe_n, bus_grant_in_n,
              grant_acknowledge_in_n, address_strobe_in_n, upper_strobe_in_n,
              lower_strobe_in_n, read_write_in}; // see RULE1
      fs2 <= fs1;
    end
  end
  logic cs;
  logic vf;
  logic grant_seen;
  logic grant_ack_seen;
  logic as_in;
  logic upper_sel;
  logic lower_sel;
  logic rw;
  assign cs = !fs2[7];
  assign vf = !fs2[6];
  assign grant_seen = !fs2[5];
  assign grant_ack_seen = !fs2[4];
  assign as_in = !fs2[3];
  assign upper_sel = !fs2[2];
  assign lower_sel = !fs2[1];
  assign rw = fs2[0];

  // Rising-edge synchronisers for exceptions, demands, lines, acknowledge
  logic [3+2*CH:0] rs1;
  logic [3+2*CH:0] rs2;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rs1 <= '1;
      rs2 <= '1;
    end
    else
    begin
      rs1 <= {exception_code_n, demand_n, peripheral_line_n,
              transfer_acknowledge_in_n}; // see RULE2
      rs2 <= rs1;
    end
  end
  logic [2:0] exc;
  logic [CH-1:0] demand_s;
  logic ack_seen;
  assign exc = ~rs2[3+2*CH -: 3]; // Encoded by outside logic, see RULE17
  assign demand_s = rs2[2*CH:CH+1];
  assign ack_seen = !rs2[0];

  demand_detect #(.CH(CH)) u_demand (
    .clk(clk),
    .reset_n(reset_n),
    .demand_n(demand_s),
    .request_mode(external_demand_style), // see RULE23
    .served(served),
    .pending(pending)
  );

  // Mode and host answer terms, declared early as the sequencer reads host_ds, vector and vf_cycle
  logic dma;
  logic host;
  logic host_ds;
  logic irq;
  logic [7:0] vector;
  logic vf_cycle;

  // Arbitration and DMA cycle sequencing
  arb_state_e state;
  logic [1:0] phase;
  logic cyc_rd;
  logic [2:0] cyc_sp;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state <= ARB_IDLE;
      phase <= 2'h0;
      cyc_rd <= 1'b1;
      cyc_sp <= `FC_RESET;
      cycle_done <= 1'b0;
      cycle_exception <= `EXC_NONE;
      address_error <= 1'b0;
      cycle_read_data <= 16'h0000;
      lanes_out <= 16'h0000;
      low_address_out <= 7'h00;
    end
    else
    begin
      cycle_done <= 1'b0;
      address_error <= 1'b0;
      // Host answers use the lanes only while the bus is not owned
      if (vf_cycle)
        lanes_out <= {8'h00, vector}; // see RULE20
      else if (host_ds && rw)
        lanes_out <= reg_read_data;
      case (state)
        ARB_IDLE:
          if (cycle_start && !cs)
            state <= ARB_REQ;
        ARB_REQ:
          if (grant_seen)
            state <= ARB_WAIT;
        ARB_WAIT:
          if (!as_in && !grant_ack_seen)
            state <= ARB_OWN; // Grant no longer watched after this, see RULE18
        ARB_OWN:
          if (release_bus)
            state <= ARB_IDLE;
          else if (cycle_start)
          begin
            state <= ARB_CYCLE;
            phase <= 2'h0;
            cyc_rd <= cycle_read;
            cyc_sp <= cycle_space;
            low_address_out <= cycle_address[7:1]; // see RULE5
            lanes_out <= cycle_address[23:8]; // see RULE4
          end
        ARB_CYCLE:
        begin
          if (phase != 2'h3)
            phase <= phase + 2'h1;
          if (phase == 2'h1 && !cyc_rd)
            lanes_out <= cycle_write_data; // Data follows the address phase
          if (cs)
          begin
            state <= ARB_OWN; // Own cycle aborted, see RULE7
            address_error <= 1'b1;
            cycle_done <= 1'b1;
          end
          else if (phase == 2'h3 && exc != `EXC_NONE && exc != `EXC_HALT)
          begin
            state <= ARB_OWN; // Exception beats acknowledge, see RULE16
            cycle_exception <= exc;
            cycle_done <= 1'b1;
          end
          else if (phase == 2'h3 && ack_seen)
          begin
            state <= ARB_OWN; // see RULE15
            cycle_exception <= `EXC_NONE;
            cycle_read_data <= lanes_in;
            cycle_done <= 1'b1;
          end
        end
        default:
          state <= ARB_IDLE;
      endcase
    end
  end

  // Mode decode; an answered vector fetch counts as host access
  assign dma = (state == ARB_OWN) || (state == ARB_CYCLE);
  assign host = cs && !dma;
  assign bus_mode = dma ? MODE_DMA : ((host || vf_cycle) ? MODE_HOST : MODE_IDLE); // see RULE3
  assign other_dma_master = limited_rate && grant_ack_seen && !dma; // see RULE19
  assign bus_request_out_n = !(state == ARB_REQ || state == ARB_WAIT);

  logic in_cycle;
  assign in_cycle = state == ARB_CYCLE;
  assign grant_acknowledge_out_n = 1'b0;
  assign grant_acknowledge_oe = dma; // see RULE19
  assign address_strobe_out_n = !(in_cycle && phase != 2'h0); // see RULE8
  assign address_strobe_oe = in_cycle;
  assign upper_strobe_out_n = !(in_cycle && phase[1]);
  assign lower_strobe_out_n = !(in_cycle && phase[1]);
  assign strobe_oe = in_cycle;
  assign read_write_out = cyc_rd; // High read, low write, see RULE13
  assign read_write_oe = dma;
  assign access_space_code = cyc_sp;
  assign access_space_oe = in_cycle; // see RULE6
  assign low_address_oe = in_cycle;
  assign upper_address_latch_n = !(in_cycle && phase == 2'h0); // see RULE9
  assign upper_address_latch_oe = dma;
  assign master_n = 1'b0;
  assign master_oe = dma; // see RULE10
  assign lanes_oe = (in_cycle && (phase == 2'h0 || !cyc_rd)) || vf_cycle || (host_ds && rw);
  assign upper_lane_flag_n = !(byte_operand && cycle_address[1] == 1'b0 &&
                               |single_address); // see RULE12
  assign upper_lane_flag_oe = dma && byte_operand && |single_address;

  // Host register access: strobes stand for A0, see RULE14
  logic [1:0] ack_dly;
  assign host_ds = host && as_in && (upper_sel || lower_sel);
  assign reg_index = {low_address_in, !upper_sel && lower_sel}; // see RULE5
  assign reg_write_data = lanes_in;
  assign reg_write = host_ds && !rw && ack_dly == 2'h1;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      ack_dly <= 2'h0;
    else if (!host_ds && !vf_cycle)
      ack_dly <= 2'h0;
    else if (ack_dly != 2'h3)
      ack_dly <= ack_dly + 2'h1;
  end

  // Interrupt vector: lowest channel number wins; only while requesting
  assign irq = |(irq_normal | irq_error);
  assign interrupt_oe = irq;
  always_comb
  begin
    vector = `VEC_RESET;
    for (int k = CH - 1; k >= 0; k--)
      if (irq_error[k])
        vector = error_vector[8*k +: 8]; // see RULE20
      else if (irq_normal[k])
        vector = normal_vector[8*k +: 8];
  end
  assign vf_cycle = vf && irq && as_in && !dma; // see RULE21

  // Buffer steering and host answer
  logic host_active;
  assign host_active = host_ds || vf_cycle;
  assign transfer_acknowledge_out_n = !(host_active && ack_dly[1]); // see RULE15
  assign transfer_acknowledge_oe = host || vf_cycle;
  assign buffer_direction = dma ? !cyc_rd : rw; // Low in, high out, see RULE11
  assign buffer_direction_oe = dma || host_active;
  assign buffer_enable_n = !((in_cycle && phase != 2'h0) || host_active);
  assign buffer_enable_oe = dma || host_active;
endmodule : transfer_controller_bus
`default_nettype wire

// ==== transfer_controller_bus_properties.sv ====
// Port-level checker for the transfer controller bus interface
`default_nettype none
module transfer_controller_bus_properties
  import bus_if_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] bus_mode,
  input wire logic master_n,
  input wire logic master_oe,
  input wire logic access_space_oe,
  input wire logic upper_address_latch_oe,
  input wire logic buffer_direction_oe,
  input wire logic buffer_enable_oe,
  input wire logic upper_lane_flag_oe,
  input wire logic read_write_oe,
  input wire logic transfer_acknowledge_oe,
  input wire logic grant_acknowledge_oe,
  input wire logic grant_acknowledge_out_n,
  input wire logic address_strobe_oe,
  input wire logic cycle_done,
  input wire logic address_error
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Pins that may only be driven while the bus is owned
  property p_space_dma; access_space_oe |-> bus_mode == MODE_DMA; endproperty
  a_space_dma: assert property (p_space_dma) else $error("space code driven outside dma");
  property p_latch_dma; upper_address_latch_oe |-> bus_mode == MODE_DMA; endproperty
  a_latch_dma: assert property (p_latch_dma) else $error("latch driven outside dma");
  property p_lane_dma; upper_lane_flag_oe |-> bus_mode == MODE_DMA; endproperty
  a_lane_dma: assert property (p_lane_dma) else $error("lane flag driven outside dma");
  property p_rw_dma; read_write_oe |-> bus_mode == MODE_DMA; endproperty
  a_rw_dma: assert property (p_rw_dma) else $error("read write driven outside dma");
  property p_as_dma; address_strobe_oe |-> bus_mode == MODE_DMA; endproperty
  a_as_dma: assert property (p_as_dma) else $error("strobe driven outside dma");
  // Owner indicators follow the mode: master both ways, grant acknowledge only into DMA
  property p_master; (bus_mode == MODE_DMA) == (master_oe && !master_n); endproperty
  a_master: assert property (p_master) else $error("master indicator wrong");
  property p_gack; bus_mode == MODE_DMA |-> grant_acknowledge_oe && !grant_acknowledge_out_n;
  endproperty
  a_gack: assert property (p_gack) else $error("grant acknowledge not driven");
  property p_buf_idle; bus_mode == MODE_IDLE |-> !buffer_direction_oe && !buffer_enable_oe;
  endproperty
  a_buf_idle: assert property (p_buf_idle) else $error("buffer control driven idle");
  property p_ack_host; transfer_acknowledge_oe |-> bus_mode == MODE_HOST; endproperty
  a_ack_host: assert property (p_ack_host) else $error("acknowledge driven outside host");
  // Done is a single-cycle pulse, so a stuck flag is caught
  property p_done; cycle_done |=> !cycle_done; endproperty
  a_done: assert property (p_done) else $error("done held longer than one cycle");
  c_dma: cover property (bus_mode == MODE_DMA);
  c_host: cover property (bus_mode == MODE_HOST);
  c_abort: cover property (address_error);
endmodule : transfer_controller_bus_properties
bind transfer_controller_bus transfer_controller_bus_properties chk (.clk(clk),
  .reset_n(reset_n), .bus_mode(bus_mode), .master_n(master_n), .master_oe(master_oe),
  .access_space_oe(access_space_oe), .upper_address_latch_oe(upper_address_latch_oe),
  .buffer_direction_oe(buffer_direction_oe), .buffer_enable_oe(buffer_enable_oe),
  .upper_lane_flag_oe(upper_lane_flag_oe), .read_write_oe(read_write_oe),
  .transfer_acknowledge_oe(transfer_acknowledge_oe), .grant_acknowledge_oe(grant_acknowledge_oe),
  .grant_acknowledge_out_n(grant_acknowledge_out_n), .address_strobe_oe(address_strobe_oe),
  .cycle_done(cycle_done), .address_error(address_error));
`default_nettype wire
